//--- pif_pkg.sv
// Package of constants and types shared by both ends of the peripheral interrupt flag block.
package pif_pkg;

  // ********************************************************************
  // Flag register layout
  // ********************************************************************
  localparam logic [7:0] PIF_FLAGS_OFFSET = 8'h0c;
  localparam logic [7:0] PIF_FLAGS_RESET = 8'h00;
  localparam int PIF_PARALLEL_BIT = 7;
  localparam int PIF_CONV_BIT = 6;
  localparam int PIF_RX_BIT = 5;
  localparam int PIF_TX_BIT = 4;
  localparam int PIF_SYNC_BIT = 3;
  localparam int PIF_CC_BIT = 2;
  localparam int PIF_PERIOD_BIT = 1;
  localparam int PIF_OVF_BIT = 0;
  // Bits software may load; the two serial buffer bits are excluded.
  localparam logic [7:0] PIF_WRITABLE_MASK = 8'hcf;

  // ********************************************************************
  // Controller registers on APB
  // ********************************************************************
  localparam logic [11:0] PIF_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] PIF_WDATA_OFFSET = 12'h004;
  localparam logic [11:0] PIF_FLAGS_RD_OFFSET = 12'h008;
  localparam logic [11:0] PIF_IRQ_STATUS_OFFSET = 12'h00c;
  localparam logic [11:0] PIF_IRQ_CLEAR_OFFSET = 12'h010;
  localparam logic [11:0] PIF_IRQ_ENABLE_OFFSET = 12'h014;
  localparam logic [31:0] PIF_CTRL_RESET = 32'h0000_0000;
  localparam int PIF_CTRL_REQ_BIT = 0;
  localparam int PIF_CTRL_RD_BIT = 1;
  localparam int PIF_CTRL_PIE_BIT = 2;
  localparam int PIF_CTRL_RXRD_BIT = 3;
  localparam int PIF_CTRL_TXWR_BIT = 4;
  localparam int PIF_EVT_DONE_BIT = 0;
  localparam int PIF_EVT_REQ_BIT = 1;

  // Capture/compare unit modes.
  typedef enum logic [1:0] {
    PIF_CC_CAPTURE = 2'h0,
    PIF_CC_COMPARE = 2'h1,
    PIF_CC_PWM = 2'h3
  } pif_cc_mode_t;

  // Host access sequencer states, Gray coded along idle, access, done.
  typedef enum logic [1:0] {
    PIF_ST_IDLE = 2'b00,
    PIF_ST_ACCESS = 2'b01,
    PIF_ST_DONE = 2'b11
  } pif_state_t;

endpackage : pif_pkg

//--- pif_if.sv
// Interface joining the flag register to the processor-side controller.
`timescale 1ns/10ps
`default_nettype none
interface pif_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic [7:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_data;
  logic rx_data_read;
  logic tx_data_write;
  logic [7:0] int_enable;
  logic peripheral_int_enable;
  logic periph_irq;

  modport device (
    input wr_data, wr_en, rd_en, rx_data_read, tx_data_write,
    input int_enable, peripheral_int_enable,
    output rd_data, periph_irq
  );
  modport host (
    output wr_data, wr_en, rd_en, rx_data_read, tx_data_write,
    output int_enable, peripheral_int_enable,
    input rd_data, periph_irq
  );
endinterface : pif_if
`default_nettype wire

//--- pif_flags.sv
// Peripheral event flag register: the device end.
`timescale 1ns/10ps
`default_nettype none
module pif_flags (
  input wire logic pclk,
  input wire logic presetn,
  pif_if.device bus,
  input wire logic parallel_access,
  input wire logic conversion_done,
  input wire logic rx_buffer_full,
  input wire logic tx_buffer_empty,
  input wire logic sync_serial_done,
  input wire pif_pkg::pif_cc_mode_t cc_mode,
  input wire logic cc_capture,
  input wire logic cc_match,
  input wire logic period_match,
  input wire logic timer_overflow
);

  // ********************************************************************
  // Event gathering
  // ********************************************************************
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] set_vec;
  logic cc_event;
  logic rx_q;
  logic tx_q;

  // Pulse-width mode drives no flag at all.
  assign cc_event = (cc_mode == pif_pkg::PIF_CC_CAPTURE) ? cc_capture :
                    (cc_mode == pif_pkg::PIF_CC_COMPARE) ? cc_match : 1'b0;

  // Set strobes ignore every enable.
  always_comb begin
    set_vec = 8'h00;
    set_vec[pif_pkg::PIF_PARALLEL_BIT] = parallel_access;
    set_vec[pif_pkg::PIF_CONV_BIT] = conversion_done;
    set_vec[pif_pkg::PIF_SYNC_BIT] = sync_serial_done;
    set_vec[pif_pkg::PIF_CC_BIT] = cc_event;
    set_vec[pif_pkg::PIF_PERIOD_BIT] = period_match;
    set_vec[pif_pkg::PIF_OVF_BIT] = timer_overflow;
  end

  // Software write loads writable bits; a same-cycle event still wins.
  always_comb begin
    flags_d = flags_q;
    if (bus.wr_en) begin
      flags_d = (flags_q & ~pif_pkg::PIF_WRITABLE_MASK) |
                (bus.wr_data & pif_pkg::PIF_WRITABLE_MASK);
    end
    flags_d = flags_d | set_vec;
    flags_d[pif_pkg::PIF_RX_BIT] = rx_q;
    flags_d[pif_pkg::PIF_TX_BIT] = tx_q;
  end

  // ********************************************************************
  // Serial buffer status
  // ********************************************************************
  // A data register access drops the bit at once, before the buffer
  // status catches up, so software never sees a stale request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      rx_q <= rx_buffer_full & ~bus.rx_data_read;
      tx_q <= tx_buffer_empty & ~bus.tx_data_write;
    end
  end

  // Flag register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= pif_pkg::PIF_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Read data and request are registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.rd_data <= 8'h00;
      bus.periph_irq <= 1'b0;
    end else begin
      bus.rd_data <= flags_d;
      bus.periph_irq <= bus.peripheral_int_enable & (|(flags_d & bus.int_enable));
    end
  end

endmodule : pif_flags
`default_nettype wire

//--- pif_host.sv
// Processor-side controller driving the flag register, with an APB slave.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module pif_host (
  input wire logic pclk,
  input wire logic presetn,
  pif_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  // ********************************************************************
  // Register decode
  // ********************************************************************
  logic [31:0] ctrl_q;
  logic [7:0] wdata_q;
  logic [7:0] flags_seen_q;
  logic [1:0] status_q;
  logic [1:0] enable_q;
  logic [31:0] rdata_d;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic done_evt;
  logic req_evt;
  logic req_q;
  pif_pkg::pif_state_t state_q;
  pif_pkg::pif_state_t state_d;
  // Named register selects and write strobes, decoded once and shared.
  logic sel_ctrl;
  logic sel_wdata;
  logic sel_flags;
  logic sel_status;
  logic sel_clear;
  logic sel_enable;
  logic ctrl_wr;
  logic wdata_wr;
  logic clear_wr;
  logic enable_wr;
  logic start_access;
  logic [1:0] status_clr;
  logic [1:0] status_set;

  function automatic logic sel(input logic [11:0] a, input logic [11:0] off);
    sel = (a == off);
  endfunction : sel

  // Each register select is decoded once; the read mux, write strobes and hit decode all draw on these.
  assign sel_ctrl = sel(paddr, pif_pkg::PIF_CTRL_OFFSET);
  assign sel_wdata = sel(paddr, pif_pkg::PIF_WDATA_OFFSET);
  assign sel_flags = sel(paddr, pif_pkg::PIF_FLAGS_RD_OFFSET);
  assign sel_status = sel(paddr, pif_pkg::PIF_IRQ_STATUS_OFFSET);
  assign sel_clear = sel(paddr, pif_pkg::PIF_IRQ_CLEAR_OFFSET);
  assign sel_enable = sel(paddr, pif_pkg::PIF_IRQ_ENABLE_OFFSET);

  // Writes take effect only in the access phase; read data is taken at setup.
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~pwrite;
  assign ctrl_wr = wr_acc & sel_ctrl;
  assign wdata_wr = wr_acc & sel_wdata;
  assign clear_wr = wr_acc & sel_clear;
  assign enable_wr = wr_acc & sel_enable;
  // An address outside the map answers with an error and has no effect.
  assign hit = sel_ctrl | sel_wdata | sel_flags | sel_status | sel_clear | sel_enable;

  // Read mux; the clear register is write-only and reads zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sel_ctrl) begin
      rdata_d = ctrl_q;
    end else if (sel_wdata) begin
      rdata_d = {24'h00_0000, wdata_q};
    end else if (sel_flags) begin
      rdata_d = {24'h00_0000, flags_seen_q};
    end else if (sel_status) begin
      rdata_d = {30'h000_0000, status_q};
    end else if (sel_enable) begin
      rdata_d = {30'h000_0000, enable_q};
    end
  end

  // No wait state: setup cycle, then the access phase answers at once.
  // The error flag and read data stand on the same cycle as the ready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata <= rd_acc ? rdata_d : 32'h0000_0000;
    end
  end

  // ********************************************************************
  // Access sequencer toward the flag register
  // ********************************************************************
  // Control writes with the request bit start one flag access.
  always_comb begin
    state_d = state_q;
    case (state_q)
      pif_pkg::PIF_ST_IDLE: begin
        if (ctrl_q[pif_pkg::PIF_CTRL_REQ_BIT]) begin
          state_d = pif_pkg::PIF_ST_ACCESS;
        end
      end
      pif_pkg::PIF_ST_ACCESS: state_d = pif_pkg::PIF_ST_DONE;
      default: state_d = pif_pkg::PIF_ST_IDLE;
    endcase
  end

  assign done_evt = (state_q == pif_pkg::PIF_ST_DONE);
  assign req_evt = link.periph_irq & ~req_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pif_pkg::PIF_ST_IDLE;
      req_q <= 1'b0;
      flags_seen_q <= 8'h00;
    end else begin
      state_q <= state_d;
      req_q <= link.periph_irq;
      if (done_evt) begin
        flags_seen_q <= link.rd_data;
      end
    end
  end

  // Control and data registers; the request bit self-clears on start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pif_pkg::PIF_CTRL_RESET;
      wdata_q <= 8'h00;
      enable_q <= 2'b00;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= pwdata;
      end else if (state_q == pif_pkg::PIF_ST_IDLE) begin
        ctrl_q[pif_pkg::PIF_CTRL_REQ_BIT] <= 1'b0;
      end
      if (wdata_wr) begin
        wdata_q <= pwdata[7:0];
      end
      if (enable_wr) begin
        enable_q <= pwdata[1:0];
      end
    end
  end

  // ********************************************************************
  // Interrupt status
  // ********************************************************************
  // Ones written to the clear register drop status bits; nothing else does.
  assign status_clr = clear_wr ? pwdata[1:0] : 2'b00;

  // Event positions come from the package so software and logic agree.
  always_comb begin
    status_set = 2'b00;
    status_set[pif_pkg::PIF_EVT_DONE_BIT] = done_evt;
    status_set[pif_pkg::PIF_EVT_REQ_BIT] = req_evt;
  end

  // Sticky status: a new event wins over a clear in the same cycle.
  // The output is registered, so it trails the status by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 2'b00;
      irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
      irq <= |(status_q & enable_q);
    end
  end

  // Strobes fire in the cycle the sequencer enters its access state, so
  // each control write with the request bit yields exactly one strobe of each selected kind.
  assign start_access = (state_d == pif_pkg::PIF_ST_ACCESS);

  // Strobes toward the device; software is expected to clear flags
  // before it raises enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.wr_en <= 1'b0;
      link.rd_en <= 1'b0;
      link.wr_data <= 8'h00;
      link.rx_data_read <= 1'b0;
      link.tx_data_write <= 1'b0;
      link.int_enable <= 8'h00;
      link.peripheral_int_enable <= 1'b0;
    end else begin
      link.wr_en <= start_access && !ctrl_q[pif_pkg::PIF_CTRL_RD_BIT];
      link.rd_en <= start_access && ctrl_q[pif_pkg::PIF_CTRL_RD_BIT];
      link.wr_data <= wdata_q;
      link.rx_data_read <= start_access && ctrl_q[pif_pkg::PIF_CTRL_RXRD_BIT];
      link.tx_data_write <= start_access && ctrl_q[pif_pkg::PIF_CTRL_TXWR_BIT];
      link.int_enable <= ctrl_q[15:8];
      link.peripheral_int_enable <= ctrl_q[pif_pkg::PIF_CTRL_PIE_BIT];
    end
  end

endmodule : pif_host
`default_nettype wire

//--- pif_chk.sv
// Concurrent checks on the link between the flag register and its controller.
`timescale 1ns/10ps
`default_nettype none
module pif_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rx_data_read,
  input wire logic tx_data_write,
  input wire logic [7:0] int_enable,
  input wire logic peripheral_int_enable,
  input wire logic periph_irq
);
  localparam logic [7:0] wm = pif_pkg::PIF_WRITABLE_MASK;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ******************************************************************
  // Properties
  // ******************************************************************
  // A same-cycle event beats a clear, so only the written ones must land.
  property p_load;
    wr_en |=> (rd_data & $past(wr_data) & wm) == ($past(wr_data) & wm);
  endproperty
  // A writable flag only falls after a write.
  property p_sticky;
    (($past(rd_data) & ~rd_data & wm) != 8'h00) |-> $past(wr_en);
  endproperty
  property p_rx_clr;
    rx_data_read |-> ##2 !rd_data[pif_pkg::PIF_RX_BIT];
  endproperty
  property p_tx_clr;
    tx_data_write |-> ##2 !rd_data[pif_pkg::PIF_TX_BIT];
  endproperty
  property p_irq_pie;
    (!peripheral_int_enable)[*2] |-> !periph_irq;
  endproperty
  property p_irq_en;
    (int_enable == 8'h00)[*2] |-> !periph_irq;
  endproperty
  // Serial bits lag one more cycle in the image, so they are left out here.
  property p_irq_on;
    (peripheral_int_enable && (rd_data & int_enable & wm) != 8'h00)[*3] |-> periph_irq;
  endproperty
  property p_irq_rise;
    $rose(periph_irq) |-> $past(peripheral_int_enable);
  endproperty
  a_load: assert property (p_load) else $error("written flag bits not loaded");
  a_sticky: assert property (p_sticky) else $error("flag fell without a write");
  a_rx_clr: assert property (p_rx_clr) else $error("receive flag not cleared");
  a_tx_clr: assert property (p_tx_clr) else $error("transmit flag not cleared");
  a_irq_pie: assert property (p_irq_pie) else $error("request without enable");
  a_irq_en: assert property (p_irq_en) else $error("request with no bit on");
  a_irq_on: assert property (p_irq_on) else $error("request missing");
  a_irq_rise: assert property (p_irq_rise) else $error("request rose while off");
  c_wr: cover property (wr_en);
  c_rd: cover property (rd_en);
  c_rx: cover property (rx_data_read);
  c_tx: cover property (tx_data_write);
  c_irq: cover property ($rose(periph_irq));
endmodule : pif_chk
`default_nettype wire

//--- tb_peripheral_interrupt_flags.sv
// Self-checking testbench for both ends of the peripheral flag block.
`timescale 1ns/10ps
`default_nettype none
module tb_peripheral_interrupt_flags;
  // ******************************************************************
  // Stimulus and wiring
  // ******************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [7:0] ev = 8'h00;
  logic cc_hit = 1'b0;
  logic rx_full = 1'b0;
  logic tx_empty = 1'b0;
  pif_pkg::pif_cc_mode_t cc_mode = pif_pkg::PIF_CC_CAPTURE;
  logic [31:0] cfg = 32'h0000_0000;
  int mismatches = 0;
  int total_checks = 0;
  always #2.5 pclk = ~pclk;
  pif_if i_pif_if (.pclk(pclk), .presetn(presetn));
  pif_flags i_pif_flags (.pclk(pclk), .presetn(presetn), .bus(i_pif_if),
    .parallel_access(ev[7]), .conversion_done(ev[6]), .rx_buffer_full(rx_full),
    .tx_buffer_empty(tx_empty), .sync_serial_done(ev[3]), .cc_mode(cc_mode),
    .cc_capture(ev[2]), .cc_match(cc_hit), .period_match(ev[1]), .timer_overflow(ev[0]));
  pif_host i_pif_host (.pclk(pclk), .presetn(presetn), .link(i_pif_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  pif_chk i_pif_chk (.pclk(pclk), .presetn(presetn), .wr_data(i_pif_if.wr_data),
    .wr_en(i_pif_if.wr_en), .rd_en(i_pif_if.rd_en), .rd_data(i_pif_if.rd_data),
    .rx_data_read(i_pif_if.rx_data_read), .tx_data_write(i_pif_if.tx_data_write),
    .int_enable(i_pif_if.int_enable), .peripheral_int_enable(i_pif_if.peripheral_int_enable),
    .periph_irq(i_pif_if.periph_irq));
  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // The wait is bounded only by the watchdog; no answer latency is assumed.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One controller access: start it, wait for done, acknowledge, fetch the image.
  task automatic acc(input logic [31:0] c, output logic [7:0] f);
    logic [31:0] r;
    logic e;
    apb(1'b1, pif_pkg::PIF_CTRL_OFFSET, c | cfg | 32'h1, r, e);
    r = 32'h0;
    while (r[0] !== 1'b1) apb(1'b0, pif_pkg::PIF_IRQ_STATUS_OFFSET, 32'h0, r, e);
    apb(1'b1, pif_pkg::PIF_IRQ_CLEAR_OFFSET, 32'h1, r, e);
    apb(1'b0, pif_pkg::PIF_FLAGS_RD_OFFSET, 32'h0, r, e);
    f = r[7:0];
  endtask : acc
  task automatic wrf(input logic [7:0] v, output logic [7:0] f);
    logic [31:0] r;
    logic e;
    apb(1'b1, pif_pkg::PIF_WDATA_OFFSET, {24'h0, v}, r, e);
    acc(32'h0, f);
    acc(32'h2, f);
  endtask : wrf
  task automatic pulse(input logic [7:0] m, input logic c);
    @(posedge pclk);
    ev <= m;
    cc_hit <= c;
    @(posedge pclk);
    ev <= 8'h00;
    cc_hit <= 1'b0;
  endtask : pulse
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    chk(i_pif_if.rd_data, pif_pkg::PIF_FLAGS_RESET);
    apb(1'b0, pif_pkg::PIF_CTRL_OFFSET, 32'h0, r, e);
    chk(r, pif_pkg::PIF_CTRL_RESET);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask : t_reset
  // Every event source except the two serial buffers sets its own bit with all enables off, then is cleared.
  task automatic t_events();
    logic [7:0] f;
    for (int i = 0; i < 8; i++) begin
      if (i == 4 || i == 5) continue;
      pulse(8'h01 << i, 1'b0);
      acc(32'h2, f);
      chk(f, 8'h01 << i);
      wrf(8'h00, f);
      chk(f, 8'h00);
    end
    cc_mode <= pif_pkg::PIF_CC_COMPARE;
    pulse(8'h00, 1'b1);
    acc(32'h2, f);
    chk(f, 8'h04);
    wrf(8'h00, f);
    cc_mode <= pif_pkg::PIF_CC_PWM;
    pulse(8'h04, 1'b1);
    acc(32'h2, f);
    chk(f, 8'h00);
    cc_mode <= pif_pkg::pif_cc_mode_t'(2'h2);
    pulse(8'h04, 1'b1);
    acc(32'h2, f);
    chk(f, 8'h00);
  endtask : t_events
  // Serial bits follow the buffer levels and ignore writes.
  task automatic t_serial();
    logic [7:0] f;
    wrf(8'hff, f);
    chk(f, 8'hff & pif_pkg::PIF_WRITABLE_MASK);
    rx_full <= 1'b1;
    tx_empty <= 1'b1;
    wrf(8'h00, f);
    chk(f, 8'h30);
    acc(32'h1a, f);
    rx_full <= 1'b0;
    tx_empty <= 1'b0;
    acc(32'h2, f);
    chk(f, 8'h00);
  endtask : t_serial
  // Flags are cleared while the enables rise, then the peripheral enable bit gates the request.
  task automatic t_irq();
    logic [7:0] f;
    logic [31:0] r;
    logic e;
    cfg = 32'h0000_0204;
    wrf(8'h00, f);
    chk(i_pif_if.periph_irq, 1'b0);
    pulse(8'h02, 1'b0);
    acc(32'h2, f);
    chk(f, 8'h02);
    chk(i_pif_if.periph_irq, 1'b1);
    apb(1'b1, pif_pkg::PIF_IRQ_ENABLE_OFFSET, 32'h2, r, e);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wrf(8'h00, f);
    chk(i_pif_if.periph_irq, 1'b0);
    apb(1'b1, pif_pkg::PIF_IRQ_CLEAR_OFFSET, 32'h2, r, e);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    cfg = 32'h0000_0200;
    wrf(8'h00, f);
    pulse(8'h02, 1'b0);
    acc(32'h2, f);
    chk(f, 8'h02);
    chk(i_pif_if.periph_irq, 1'b0);
    cfg = 32'h0000_0000;
    wrf(8'h00, f);
  endtask : t_irq
  // ******************************************************************
  // Main sequence and watchdog
  // ******************************************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_events();
    t_serial();
    // Flags were cleared above before any enable is raised.
    t_irq();
    close_out();
  end
  // The run needs under a thousand cycles; the limit leaves a wide margin.
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    close_out();
  end
endmodule : tb_peripheral_interrupt_flags
`default_nettype wire
